// File: src/ssio_core.sv
// clock synchronous serial channel: 8-bit full duplex shifter, bit rate
// generator, handshake line, register port and one level interrupt
// assumes pins and register strobes are synchronous to core_clk
//
// Behaviour
// - eight bits shifted out and in together
// - internal clock is source over 2(n+1)
// - divisor is an eight-bit field 0..255
// - external source selected takes clock from pin
// - handshake line is cts, rts or unused
// - start needs tx enable, data, cts low in cts mode
// - receive needs rx and tx enable, data
// - cause zero: tx irq on buffer move
// - cause one: tx irq after frame sent
// - rx irq when frame reaches receive buffer without overrun
// - overrun when buffer still unread
// - overrun overwrites receive buffer with new frame
// - overrun sets no receive irq
// - data output high or floating before transfer
// - lsb first when clear, msb first when set
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ssio_core
  import ssio_pkg::*;
#(
  parameter int unsigned DIV_W = DIV_BITS
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  output logic                   irq,
  output logic                   serialOutPin,
  output logic                   serialOutPinOen,
  input  wire logic              serialInPin,
  input  wire logic              transferClockPinIn,
  output logic                   transferClockPinOut,
  output logic                   transferClockPinOen,
  input  wire logic              ctsN,
  output logic                   rtsN
);
  if (DIV_W < 1 || DIV_W > DATA_W) begin : g_chk
    $error("ssio_core: DIV_W out of range");
  end

  ssio_ctrl_s      ctrl_ff, nxt_ctrl;
  ssio_state_e     state_ff, nxt_state;
  logic [DIV_W-1:0] div_ff, nxt_div, brg_ff, nxt_brg;
  logic [7:0]      txBuf_ff, nxt_txBuf, rxBuf_ff, nxt_rxBuf;
  logic [7:0]      sh_ff, nxt_sh;
  logic [3:0]      bitCnt_ff, nxt_bitCnt;
  logic [4:0]      pre_ff, nxt_pre;
  logic [IRQ_W-1:0] iStat_ff, nxt_iStat, iMask_ff, nxt_iMask;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic            txEmpty_ff, nxt_txEmpty, txEnd_ff, nxt_txEnd;
  logic            rxFull_ff, nxt_rxFull, rxAct_ff, nxt_rxAct;
  logic            clkOut_ff, nxt_clkOut, clkOen_ff, nxt_clkOen;
  logic            dOut_ff, nxt_dOut, dOen_ff, nxt_dOen;
  logic            rts_ff, nxt_rts, ckPrev_ff, irq_ff, nxt_irq;
  logic            srcTick, halfTick, idleLvl, lead, trail, start, done;
  logic            rdRx, outBit;
  logic [7:0]      shIn;

  always_comb begin
    idleLvl  = ~ctrl_ff.clkPol;
    rdRx     = regRd && (regAddr == OFS_RXBUF);
    nxt_pre  = pre_ff + 5'h01;
    case (ctrl_ff.srcSel)
      SRC_UNDIV: srcTick = 1'b1;
      SRC_DIV8:  srcTick = (pre_ff & PRE_DIV8) == PRE_DIV8;
      default:   srcTick = pre_ff == PRE_DIV32;
    endcase
    // half period is n+1 source ticks, so a full period is 2(n+1)
    halfTick = (state_ff == ST_RUN) && !ctrl_ff.extClk && srcTick
               && (brg_ff == div_ff);
    if (ctrl_ff.extClk) begin
      lead  = (state_ff == ST_RUN) && (ckPrev_ff == idleLvl)
              && (transferClockPinIn != idleLvl);
      trail = (state_ff == ST_RUN) && (ckPrev_ff != idleLvl)
              && (transferClockPinIn == idleLvl);
    end else begin
      lead  = halfTick && (clkOut_ff == idleLvl);
      trail = halfTick && (clkOut_ff != idleLvl);
    end
    start = (state_ff == ST_IDLE) && ctrl_ff.txEn && !txEmpty_ff
            && (ctrl_ff.hsMode != HS_CTS || !ctsN)
            && (!ctrl_ff.extClk || transferClockPinIn == idleLvl);
    done  = trail && (bitCnt_ff == BIT_LAST);
    outBit = ctrl_ff.msbFirst ? sh_ff[7] : sh_ff[0];
    shIn   = ctrl_ff.msbFirst ? {sh_ff[6:0], serialInPin}
                              : {serialInPin, sh_ff[7:1]};

    nxt_ctrl    = ctrl_ff;
    nxt_div     = div_ff;
    nxt_state   = state_ff;
    nxt_brg     = brg_ff;
    nxt_txBuf   = txBuf_ff;
    nxt_rxBuf   = rxBuf_ff;
    nxt_sh      = sh_ff;
    nxt_bitCnt  = bitCnt_ff;
    nxt_iStat   = iStat_ff;
    nxt_iMask   = iMask_ff;
    nxt_txEmpty = txEmpty_ff;
    nxt_txEnd   = txEnd_ff;
    nxt_rxFull  = rxFull_ff;
    nxt_rxAct   = rxAct_ff;
    nxt_clkOut  = clkOut_ff;
    nxt_dOut    = dOut_ff;
    nxt_rdata   = '0;

    // software clears first so that hardware events below win
    if (regWr) begin
      case (regAddr)
        OFS_CTRL:  nxt_ctrl = ssio_ctrl_s'(regWdata[CTRL_W-1:0]);
        OFS_BRG:   nxt_div = regWdata[DIV_W-1:0];
        OFS_ISTAT: nxt_iStat = iStat_ff & ~regWdata[IRQ_W-1:0];
        OFS_IMASK: nxt_iMask = regWdata[IRQ_W-1:0];
        default:   ;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        OFS_CTRL:  nxt_rdata = DATA_W'(ctrl_ff);
        OFS_BRG:   nxt_rdata = DATA_W'(div_ff);
        OFS_TXBUF: nxt_rdata = DATA_W'(txBuf_ff);
        OFS_RXBUF: nxt_rdata = DATA_W'(rxBuf_ff);
        OFS_STAT: begin
          nxt_rdata[ST_TXEMPTY] = txEmpty_ff;
          nxt_rdata[ST_TXEND]   = txEnd_ff;
          nxt_rdata[ST_RXFULL]  = rxFull_ff;
          nxt_rdata[ST_BUSY]    = state_ff == ST_RUN;
        end
        OFS_ISTAT: nxt_rdata = DATA_W'(iStat_ff);
        OFS_IMASK: nxt_rdata = DATA_W'(iMask_ff);
        default:   nxt_rdata = '0;
      endcase
    end
    if (rdRx) begin
      nxt_rxFull = 1'b0;
    end

    case (state_ff)
      ST_IDLE: begin
        nxt_brg    = '0;
        nxt_clkOut = idleLvl;
        nxt_dOut   = 1'b1;
        if (start) begin
          nxt_state   = ST_RUN;
          nxt_sh      = txBuf_ff;
          nxt_txEmpty = 1'b1;
          nxt_txEnd   = 1'b0;
          nxt_bitCnt  = '0;
          nxt_rxAct   = ctrl_ff.rxEn;
          if (!ctrl_ff.txIrqSel) begin
            nxt_iStat[IRQ_TX] = 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (srcTick) begin
          nxt_brg = (brg_ff == div_ff) ? '0 : brg_ff + 1'b1;
        end
        if (halfTick) begin
          nxt_clkOut = ~clkOut_ff;
        end
        if (lead) begin
          nxt_dOut = outBit;
        end
        if (trail) begin
          nxt_sh     = shIn;
          nxt_bitCnt = bitCnt_ff + 4'h1;
        end
        if (done) begin
          nxt_state = ST_IDLE;
          nxt_txEnd = 1'b1;
          if (ctrl_ff.txIrqSel) begin
            nxt_iStat[IRQ_TX] = 1'b1;
          end
          if (rxAct_ff) begin
            nxt_rxBuf = shIn;
            if (rxFull_ff && !rdRx) begin
              nxt_iStat[IRQ_OVR] = 1'b1;
            end else begin
              nxt_rxFull        = 1'b1;
              nxt_iStat[IRQ_RX] = 1'b1;
            end
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase

    // a buffer write lands after a start took the old word
    if (regWr && regAddr == OFS_TXBUF) begin
      nxt_txBuf   = regWdata[7:0];
      nxt_txEmpty = 1'b0;
    end

    nxt_clkOen = ctrl_ff.extClk;
    nxt_dOen   = ctrl_ff.openDrain && nxt_dOut;
    nxt_rts    = !(ctrl_ff.hsMode == HS_RTS && ctrl_ff.rxEn
                   && !nxt_rxFull);
    nxt_irq    = |(nxt_iStat & nxt_iMask);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff   <= CTRL_RST;
      div_ff    <= '0;
      state_ff  <= ST_IDLE;
      brg_ff    <= '0;
      txBuf_ff  <= '0;
      rxBuf_ff  <= '0;
      sh_ff     <= '0;
      bitCnt_ff <= '0;
      pre_ff    <= '0;
      iStat_ff  <= '0;
      iMask_ff  <= '0;
      rdata_ff  <= '0;
      txEmpty_ff <= 1'b1;
      txEnd_ff  <= 1'b1;
      rxFull_ff <= 1'b0;
      rxAct_ff  <= 1'b0;
      clkOut_ff <= 1'b1;
      clkOen_ff <= 1'b0;
      dOut_ff   <= 1'b1;
      dOen_ff   <= 1'b0;
      rts_ff    <= 1'b1;
      ckPrev_ff <= 1'b1;
      irq_ff    <= 1'b0;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      div_ff    <= nxt_div;
      state_ff  <= nxt_state;
      brg_ff    <= nxt_brg;
      txBuf_ff  <= nxt_txBuf;
      rxBuf_ff  <= nxt_rxBuf;
      sh_ff     <= nxt_sh;
      bitCnt_ff <= nxt_bitCnt;
      pre_ff    <= nxt_pre;
      iStat_ff  <= nxt_iStat;
      iMask_ff  <= nxt_iMask;
      rdata_ff  <= nxt_rdata;
      txEmpty_ff <= nxt_txEmpty;
      txEnd_ff  <= nxt_txEnd;
      rxFull_ff <= nxt_rxFull;
      rxAct_ff  <= nxt_rxAct;
      clkOut_ff <= nxt_clkOut;
      clkOen_ff <= nxt_clkOen;
      dOut_ff   <= nxt_dOut;
      dOen_ff   <= nxt_dOen;
      rts_ff    <= nxt_rts;
      ckPrev_ff <= transferClockPinIn;
      irq_ff    <= nxt_irq;
    end
  end

  assign regRdata            = rdata_ff;
  assign irq                 = irq_ff;
  assign serialOutPin        = dOut_ff;
  assign serialOutPinOen     = dOen_ff;
  assign transferClockPinOut = clkOut_ff;
  assign transferClockPinOen = clkOen_ff;
  assign rtsN                = rts_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_start_needs_data: assert property ($rose(state_ff == ST_RUN) |->
    $past(ctrl_ff.txEn) && !$past(txEmpty_ff))
    else $error("frame started without enable or data");
  a_start_cts_low: assert property ($rose(state_ff == ST_RUN)
    && $past(ctrl_ff.hsMode) == HS_CTS |-> $past(!ctsN))
    else $error("frame started with cts high");
  a_buf_moved: assert property (start && !(regWr && regAddr == OFS_TXBUF)
    |=> txEmpty_ff
    && state_ff == ST_RUN && sh_ff == $past(txBuf_ff))
    else $error("transmit buffer not moved at start");
  a_frame_eight_bits: assert property (state_ff == ST_RUN ##1
    state_ff == ST_IDLE |-> $past(bitCnt_ff) == BIT_LAST)
    else $error("frame ended at wrong bit count");
  a_tx_irq_move: assert property (start && !ctrl_ff.txIrqSel
    |=> iStat_ff[IRQ_TX])
    else $error("no transmit irq on buffer move");
  a_tx_irq_end: assert property (done && ctrl_ff.txIrqSel
    |=> iStat_ff[IRQ_TX] && txEnd_ff)
    else $error("no transmit irq at frame end");
  a_rx_irq_set: assert property (done && rxAct_ff && !rxFull_ff
    |=> iStat_ff[IRQ_RX] && rxFull_ff && rxBuf_ff == $past(shIn))
    else $error("received frame not posted");
  a_overrun_flag: assert property (done && rxAct_ff && rxFull_ff && !rdRx
    && !regWr |=> iStat_ff[IRQ_OVR] && rxBuf_ff == $past(shIn)
    && $stable(iStat_ff[IRQ_RX]))
    else $error("overrun handled wrongly");
  // the last bit still stands in the first idle cycle after a frame
  a_idle_out_high: assert property (state_ff == ST_IDLE
    && $past(state_ff) == ST_IDLE |-> dOut_ff)
    else $error("data output not high while idle");
  a_lead_bit_order: assert property (lead |=> dOut_ff ==
    ($past(ctrl_ff.msbFirst) ? $past(sh_ff[7]) : $past(sh_ff[0])))
    else $error("wrong bit driven at leading edge");
  a_clk_stops: assert property (state_ff == ST_IDLE ##1
    state_ff == ST_IDLE && $stable(ctrl_ff)
    |-> clkOut_ff == ~ctrl_ff.clkPol)
    else $error("internal clock running while idle");

  c_frame_int: cover property (done && !ctrl_ff.extClk);
  c_frame_ext: cover property (done && ctrl_ff.extClk);
  c_overrun: cover property (done && rxAct_ff && rxFull_ff);
  c_rts_low: cover property (!rts_ff);
endmodule
`default_nettype wire

// File: src/ssio_pkg.sv
// register map, field layout and encodings of the synchronous serial channel
// assumes a plain register port with byte offsets on a 5-bit address
package ssio_pkg;
  localparam int unsigned ADDR_W     = 5;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned FRAME_BITS = 8;
  localparam int unsigned DIV_BITS   = 8;

  localparam logic [ADDR_W-1:0] OFS_CTRL  = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_BRG   = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_TXBUF = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_RXBUF = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_ISTAT = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_IMASK = 5'h18;

  // prescaler terminal counts for the divided sources
  localparam logic [4:0] PRE_DIV8  = 5'h07;
  localparam logic [4:0] PRE_DIV32 = 5'h1f;
  localparam logic [3:0] BIT_LAST  = 4'h7;

  localparam int unsigned ST_TXEMPTY = 0;
  localparam int unsigned ST_TXEND   = 1;
  localparam int unsigned ST_RXFULL  = 2;
  localparam int unsigned ST_BUSY    = 3;

  localparam int unsigned IRQ_W   = 3;
  localparam int unsigned IRQ_TX  = 0;
  localparam int unsigned IRQ_RX  = 1;
  localparam int unsigned IRQ_OVR = 2;

  typedef enum logic [1:0] {SRC_UNDIV, SRC_DIV8, SRC_DIV32} ssio_src_e;
  typedef enum logic [1:0] {HS_NONE, HS_CTS, HS_RTS} ssio_hs_e;
  typedef enum logic {ST_IDLE, ST_RUN} ssio_state_e;

  typedef struct packed {
    logic      openDrain;
    logic      txIrqSel;
    logic      clkPol;
    logic      msbFirst;
    ssio_hs_e  hsMode;
    ssio_src_e srcSel;
    logic      extClk;
    logic      rxEn;
    logic      txEn;
  } ssio_ctrl_s;

  localparam int unsigned CTRL_W   = $bits(ssio_ctrl_s);
  localparam ssio_ctrl_s  CTRL_RST = '0;
endpackage

// File: testbench/ssio_peer.sv
// partner model: peripheral on the internal transfer clock, or master
// that drives its own transfer clock when ext is high
// assumes the clock pin idles high and toggles in step with core_clk
`timescale 1ns/1ps
`default_nettype none
module ssio_peer (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       sclk,
  input  wire logic       sdo,
  input  wire logic       msb,
  input  wire logic       arm,
  input  wire logic       ext,
  input  wire logic [7:0] reply,
  output logic            sdi,
  output logic            mclk,
  output logic      [7:0] got,
  output logic      [3:0] cnt,
  output logic      [9:0] per
);
  logic       lastClk;
  logic       ck;
  logic [3:0] hold;
  logic [9:0] tick;
  logic [2:0] idx;
  assign idx = msb ? 3'h7 - cnt[2:0] : cnt[2:0];
  assign ck  = ext ? mclk : sclk;
  // master clock idles high until the device has had time to start
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mclk <= 1'b1;
      hold <= 4'h0;
    end else if (arm) begin
      mclk <= 1'b1;
      hold <= 4'h0;
    end else if (ext && cnt < 4'h8) begin
      if (hold != 4'hc) begin
        hold <= hold + 4'h1;
      end else begin
        hold <= 4'h9;
        mclk <= ~mclk;
      end
    end
  end
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lastClk <= 1'b1;
      tick <= 10'h000;
      cnt <= 4'h8;
      sdi <= 1'b1;
      got <= 8'h00;
      per <= 10'h000;
    end else begin
      lastClk <= ck;
      tick <= tick + 10'h001;
      if (arm) begin
        cnt <= 4'h0;
        sdi <= reply[msb ? 7 : 0];
      end else if (!lastClk && ck && cnt < 4'h8) begin
        got[idx] <= sdo;
        cnt <= cnt + 4'h1;
        per <= tick + 10'h001;
        tick <= 10'h000;
        // released line shows the inverse of its last bit
        if (cnt == 4'h7)
          sdi <= ~reply[idx];
        else
          sdi <= reply[msb ? idx - 3'h1 : idx + 3'h1];
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/ssio_tb.sv
// self-checking bench of the synchronous serial channel
// assumes the partner model answers on the internal transfer clock or
// supplies the external one itself
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ssio_pkg::*;
  logic              core_clk, nrst, regWr, regRd, irq, sin, sout;
  logic              clkOut, ctsN, rtsN, arm, msb;
  logic              ext, mclk, clkOen, dOen;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata, v;
  logic [7:0]        reply, got;
  logic [3:0]        cnt;
  logic [9:0]        per;
  int                badCount, numChecks;
  // the partner's master clock stays at the idle level unless ext is set
  ssio_core DUT (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .irq(irq), .serialOutPin(sout),
    .serialOutPinOen(dOen), .serialInPin(sin), .transferClockPinIn(mclk),
    .transferClockPinOut(clkOut), .transferClockPinOen(clkOen),
    .ctsN(ctsN), .rtsN(rtsN));
  ssio_peer PEER (.core_clk(core_clk), .nrst(nrst), .sclk(clkOut),
    .sdo(sout), .msb(msb), .arm(arm), .ext(ext), .reply(reply),
    .sdi(sin), .mclk(mclk), .got(got), .cnt(cnt), .per(per));
  task chk(input logic [15:0] g, input logic [15:0] e);
    numChecks++;
    if (g !== e) begin
      badCount++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  task ctl(input logic m, sel, input ssio_hs_e h, input ssio_src_e s);
    wr(OFS_CTRL, 16'(ssio_ctrl_s'{1'b0, sel, 1'b0, m, h, s, 1'b0, 1'b1,
      1'b1}));
  endtask
  task load(input logic m, input logic [7:0] d, input logic [7:0] r);
    @(posedge core_clk);
    arm <= 1'b1;
    msb <= m;
    reply <= r;
    @(posedge core_clk);
    arm <= 1'b0;
    wr(OFS_TXBUF, {8'h00, d});
  endtask
  task waitDone;
    int i;
    for (i = 0; i < 5000 && cnt !== 4'h8; i++)
      @(posedge core_clk);
    if (cnt !== 4'h8) begin
      badCount++;
      $display("[FAIL] %0t frame did not finish", $time);
    end
    repeat (6) @(posedge core_clk);
  endtask
  task s_frame(input logic m, sel, input logic [7:0] d, input logic [7:0] r);
    ctl(m, sel, HS_NONE, SRC_UNDIV);
    wr(OFS_BRG, 16'h0001);
    wr(OFS_IMASK, 16'h0003);
    wr(OFS_ISTAT, 16'h0007);
    load(m, d, r);
    rd(OFS_ISTAT);
    chk(v & 16'h0001, {15'h0000, ~sel});
    waitDone();
    chk({8'h00, got}, {8'h00, d});
    chk({6'h00, per}, 16'h0004);
    rd(OFS_ISTAT);
    chk(v, 16'h0003);
    chk({15'h0000, irq}, 16'h0001);
    rd(OFS_RXBUF);
    chk(v, {8'h00, r});
  endtask
  task s_div(input ssio_src_e s, input logic [7:0] n, input logic [9:0] e);
    ctl(1'b0, 1'b0, HS_NONE, s);
    wr(OFS_BRG, {8'h00, n});
    load(1'b0, 8'h96, 8'h69);
    waitDone();
    chk({6'h00, per}, {6'h00, e});
    rd(OFS_RXBUF);
  endtask
  task s_ovr;
    ctl(1'b0, 1'b0, HS_NONE, SRC_UNDIV);
    wr(OFS_IMASK, 16'h0000);
    load(1'b0, 8'h11, 8'h5a);
    waitDone();
    wr(OFS_ISTAT, 16'h0007);
    load(1'b0, 8'h22, 8'ha5);
    waitDone();
    rd(OFS_ISTAT);
    chk(v, 16'h0005);
    chk({15'h0000, irq}, 16'h0000);
    rd(OFS_RXBUF);
    chk(v, 16'h00a5);
    wr(OFS_ISTAT, 16'h0007);
    rd(OFS_ISTAT);
    chk(v, 16'h0000);
  endtask
  task s_ext;
    ext <= 1'b1;
    wr(OFS_CTRL, 16'(ssio_ctrl_s'{1'b1, 1'b0, 1'b0, 1'b0, HS_NONE,
      SRC_UNDIV, 1'b1, 1'b1, 1'b1}));
    wr(OFS_ISTAT, 16'h0007);
    repeat (2) @(posedge core_clk);
    #1 chk({14'h0000, clkOen, dOen}, 16'h0003);
    load(1'b0, 8'h5c, 8'hc5);
    waitDone();
    chk({8'h00, got}, 16'h005c);
    rd(OFS_RXBUF);
    chk(v, 16'h00c5);
    ext <= 1'b0;
    wr(OFS_CTRL, 16'(ssio_ctrl_s'{1'b0, 1'b0, 1'b1, 1'b0, HS_NONE,
      SRC_UNDIV, 1'b0, 1'b0, 1'b0}));
    repeat (3) @(posedge core_clk);
    #1 chk({14'h0000, clkOen, clkOut}, 16'h0000);
  endtask
  task s_hs;
    ctsN <= 1'b1;
    ctl(1'b0, 1'b0, HS_CTS, SRC_UNDIV);
    load(1'b0, 8'h3c, 8'hc3);
    repeat (40) @(posedge core_clk);
    chk({12'h000, cnt}, 16'h0000);
    chk({15'h0000, sout}, 16'h0001);
    ctsN <= 1'b0;
    waitDone();
    chk({8'h00, got}, 16'h003c);
    rd(OFS_RXBUF);
    ctl(1'b0, 1'b0, HS_RTS, SRC_UNDIV);
    repeat (3) @(posedge core_clk);
    chk({15'h0000, rtsN}, 16'h0000);
  endtask
  task endSim;
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #1000000;
    badCount++;
    $display("[FAIL] %0t watchdog expired", $time);
    endSim();
  end
  initial begin
    {nrst, regWr, regRd, arm, msb, ext} = '0;
    {regAddr, regWdata, reply} = '0;
    ctsN = 1'b0;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    rd(OFS_STAT);
    chk(v, 16'h0003);
    chk({14'h0000, sout, clkOut}, 16'h0003);
    rd(5'h1c);
    chk(v, 16'h0000);
    s_frame(1'b0, 1'b0, 8'hb4, 8'h2d);
    s_frame(1'b1, 1'b1, 8'hb4, 8'h2d);
    s_div(SRC_DIV8, 8'h00, 10'h010);
    s_div(SRC_DIV32, 8'h00, 10'h040);
    s_div(SRC_UNDIV, 8'hff, 10'h200);
    s_ovr();
    s_hs();
    s_ext();
    endSim();
  end
endmodule
`default_nettype wire
